// >>> hdl/ref_ctrl_pkg.sv
// Package with register map, field layout and constants of the reference control block.
package ref_ctrl_pkg;
    // Printed offset 9Dh is not a multiple of four, so 9Ch and 9Dh are taken as word indices.
    localparam logic [7:0]  MODE_CTRL_INDEX   = 8'h9c;
    localparam logic [7:0]  LEVEL_CTRL_INDEX  = 8'h9d;
    localparam logic [11:0] MODE_CTRL_ADDR    = {2'b00, MODE_CTRL_INDEX, 2'b00};
    localparam logic [11:0] LEVEL_CTRL_ADDR   = {2'b00, LEVEL_CTRL_INDEX, 2'b00};
    localparam logic [7:0]  MODE_CTRL_RESET   = 8'h07;
    localparam logic [7:0]  LEVEL_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  LEVEL_CTRL_MASK   = 8'hef;
    localparam logic [7:0]  MODE_CTRL_WMASK   = 8'h3f;
    localparam int          POWER_BIT         = 7;
    localparam int          PIN_DRIVE_BIT     = 6;
    localparam int          RANGE_BIT         = 5;
    localparam int          TAP_MSB           = 3;
    localparam int          MODE_MSB          = 2;
    localparam int          CMP1_OUT_BIT      = 6;
    localparam int          CMP2_OUT_BIT      = 7;
    localparam logic [2:0]  MODE_INTERNAL_REF = 3'b110;
    // Level is in 96ths of the ladder source, common denominator of 24 and 32.
    localparam logic [6:0]  QUARTER_96THS     = 7'h18;
    localparam logic [6:0]  STEP24_96THS      = 7'h04;
    localparam logic [6:0]  STEP32_96THS      = 7'h03;
endpackage

// >>> hdl/ref_level_calc.sv
// Tap code to reference level arithmetic, in 96ths of the ladder source.
`timescale 1ns/10ps
`default_nettype none
module ref_level_calc (
    input  wire logic [3:0] tap_code_i,
    input  wire logic       range_select_i,
    output logic      [6:0] level_o
);
    wire [6:0] tap_wide = {3'b000, tap_code_i};
    wire [6:0] low_range = 7'(tap_wide * ref_ctrl_pkg::STEP24_96THS);
    wire [6:0] high_range = 7'(ref_ctrl_pkg::QUARTER_96THS + tap_wide * ref_ctrl_pkg::STEP32_96THS);
    assign level_o = range_select_i ? low_range : high_range;
endmodule // ref_level_calc
`default_nettype wire

// >>> hdl/comparator_reference_control.sv
// APB register slave and digital control of the comparator voltage reference.
`timescale 1ns/10ps
`default_nettype none
module comparator_reference_control (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp1_out_i,
    input  wire logic        cmp2_out_i,
    output logic             ladder_power_o,
    output logic             pin_drive_o,
    output logic      [3:0]  tap_select_o,
    output logic      [6:0]  reference_level_o,
    output logic             cmp_internal_ref_o,
    output logic             cmp1_plus_ref_o,
    output logic             cmp2_plus_ref_o,
    output logic      [2:0]  comparator_mode_field_o
);
    logic [7:0] reference_level_control;
    logic [7:0] comparator_mode_control;
    logic [6:0] level_calc;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    wire access_phase = psel_i && penable_i;
    wire hit_level = (paddr_i == ref_ctrl_pkg::LEVEL_CTRL_ADDR);
    wire hit_mode = (paddr_i == ref_ctrl_pkg::MODE_CTRL_ADDR);
    wire mapped = hit_level || hit_mode;
    wire byte0_write = access_phase && pwrite_i && pstrb_i[0];
    wire write_level = byte0_write && hit_level;
    wire write_mode = byte0_write && hit_mode;
    // Comparator outputs are live status, the rest is stored.
    wire [7:0] mode_read = {cmp2_out_i, cmp1_out_i,
                            comparator_mode_control[5:0]};
    wire [7:0] level_read = reference_level_control & ref_ctrl_pkg::LEVEL_CTRL_MASK;
    wire [2:0] mode_field = comparator_mode_control[ref_ctrl_pkg::MODE_MSB:0];
    wire internal_ref = (mode_field == ref_ctrl_pkg::MODE_INTERNAL_REF);
    wire [3:0] tap_code = reference_level_control[ref_ctrl_pkg::TAP_MSB:0];

    ref_level_calc u_level_calc (
        .tap_code_i     (tap_code),
        .range_select_i (reference_level_control[ref_ctrl_pkg::RANGE_BIT]),
        .level_o        (level_calc)
    );

    always_comb begin
        next_prdata = prdata_o;
        next_pslverr = 1'b0;
        if (access_phase) begin
            next_pslverr = !mapped;
            if (hit_level) begin
                next_prdata = {24'h00_0000, level_read};
            end else if (hit_mode) begin
                next_prdata = {24'h00_0000, mode_read};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    // Zero-wait slave; read data is registered at the completing edge.
    assign pready_o = 1'b1;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reference_level_control <= ref_ctrl_pkg::LEVEL_CTRL_RESET;
            comparator_mode_control <= ref_ctrl_pkg::MODE_CTRL_RESET;
        end else begin
            if (write_level) begin
                reference_level_control <= pwdata_i[7:0] & ref_ctrl_pkg::LEVEL_CTRL_MASK;
            end
            if (write_mode) begin
                comparator_mode_control <= pwdata_i[7:0] & ref_ctrl_pkg::MODE_CTRL_WMASK;
            end
        end
    end

    // Data outputs come from flip-flops so the analog side never sees bus glitches.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            reference_level_o <= 7'h00;
            cmp_internal_ref_o <= 1'b0;
            cmp1_plus_ref_o <= 1'b0;
            cmp2_plus_ref_o <= 1'b0;
        end else begin
            prdata_o <= next_prdata;
            pslverr_o <= next_pslverr;
            // Powered-down ladder reports zero rather than a stale level.
            reference_level_o <= reference_level_control[ref_ctrl_pkg::POWER_BIT] ?
                                 level_calc : 7'h00;
            cmp_internal_ref_o <= internal_ref;
            cmp1_plus_ref_o <= internal_ref;
            cmp2_plus_ref_o <= internal_ref;
        end
    end

    assign ladder_power_o = reference_level_control[ref_ctrl_pkg::POWER_BIT];
    assign pin_drive_o = reference_level_control[ref_ctrl_pkg::PIN_DRIVE_BIT];
    assign tap_select_o = tap_code;
    assign comparator_mode_field_o = mode_field;
endmodule // comparator_reference_control
`default_nettype wire

// >>> tb/ref_ctrl_chk.sv
// Port assertions for the reference control block.
`timescale 1ns/10ps
`default_nettype none
module ref_ctrl_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic        ladder_power_o,
    input wire logic        pin_drive_o,
    input wire logic [3:0]  tap_select_o,
    input wire logic [6:0]  reference_level_o,
    input wire logic        cmp_internal_ref_o,
    input wire logic        cmp1_plus_ref_o,
    input wire logic        cmp2_plus_ref_o,
    input wire logic [2:0]  comparator_mode_field_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence lvl_wr;
        psel_i && penable_i && pwrite_i && pstrb_i[0] && paddr_i == ref_ctrl_pkg::LEVEL_CTRL_ADDR;
    endsequence
    chk_power_off: assert property (!ladder_power_o |=> reference_level_o == 7'h00)
        else $error("level while off");
    chk_pin_write: assert property (lvl_wr |=> {ladder_power_o, pin_drive_o} == $past(pwdata_i[7:6]))
        else $error("power or pin bit wrong");
    chk_tap_write: assert property (lvl_wr |=> tap_select_o == $past(pwdata_i[3:0]))
        else $error("tap code wrong");
    chk_level_taps: assert property (ladder_power_o |=> reference_level_o == {$past(tap_select_o), 2'b00}
        || reference_level_o == 7'h18 + 3 * $past(tap_select_o)) else $error("level off tap");
    chk_mode_on: assert property (comparator_mode_field_o == 3'b110 |=> cmp_internal_ref_o)
        else $error("internal ref missing");
    chk_mode_off: assert property (comparator_mode_field_o != 3'b110 |=> !cmp_internal_ref_o)
        else $error("internal ref stray");
    chk_both_plus: assert property (cmp1_plus_ref_o == cmp_internal_ref_o && cmp2_plus_ref_o == cmp_internal_ref_o)
        else $error("plus inputs differ");
    chk_held_idle: assert property (!(psel_i && penable_i && pwrite_i) |=> $stable({ladder_power_o, pin_drive_o, tap_select_o}))
        else $error("control changed without write");
endmodule // ref_ctrl_chk
bind comparator_reference_control ref_ctrl_chk ref_ctrl_chk_inst (.*);
`default_nettype wire

// >>> tb/comparator_reference_control_tb_top.sv
// Register-level testbench for the reference control block.
`timescale 1ns/10ps
`default_nettype none
module comparator_reference_control_tb_top;
    logic ref_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, cmp1_out_i, cmp2_out_i, pready_o, pslverr_o;
    logic ladder_power_o, pin_drive_o, cmp_internal_ref_o, cmp1_plus_ref_o, cmp2_plus_ref_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0]  pstrb_i, tap_select_o;
    logic [6:0]  reference_level_o;
    logic [2:0]  comparator_mode_field_o;
    int          n_errors, compares;
    logic        last_err;
    comparator_reference_control comparator_reference_control_inst (.*);
    initial begin
        ref_clk_i = 0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Level and mode outputs are registered from the written register, so the task waits one edge past completion.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (!pready_o && ++n < 16);
        if (n >= 16) begin
            n_errors++;
            close_out;
        end
        {psel_i, penable_i} <= 2'b00;
        // The error flag stands for one cycle only, so it is caught right after completion.
        #1 last_err = pslverr_o;
        @(posedge ref_clk_i);
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(prdata_o, exp);
    endtask
    initial begin
        {reset_n_i, psel_i, penable_i, pwrite_i, cmp1_out_i, cmp2_out_i, paddr_i, pwdata_i} = '0;
        pstrb_i = 4'h1;
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_0000);
        rd(ref_ctrl_pkg::MODE_CTRL_ADDR, 32'h0000_0007);
        chk(32'(last_err), 32'h0000_0000);
        chk(32'(comparator_mode_field_o), 32'h0000_0007);
        xfer(1'b1, ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_00ff);
        rd(ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_00ef);
        chk({ladder_power_o, pin_drive_o, tap_select_o}, 32'h0000_003f);
        pstrb_i <= 4'h0;
        xfer(1'b1, ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_0000);
        pstrb_i <= 4'h1;
        rd(ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_00ef);
        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 16; t++) begin
                xfer(1'b1, ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'(8'h80 + 32 * r + t));
                chk(reference_level_o, r ? t * 4 : 24 + t * 3);
            end
        end
        xfer(1'b1, ref_ctrl_pkg::LEVEL_CTRL_ADDR, 32'h0000_002f);
        chk(reference_level_o, 32'h0000_0000);
        cmp1_out_i <= 1'b1;
        xfer(1'b1, ref_ctrl_pkg::MODE_CTRL_ADDR, 32'h0000_0006);
        rd(ref_ctrl_pkg::MODE_CTRL_ADDR, 32'h0000_0046);
        chk({cmp_internal_ref_o, cmp1_plus_ref_o, cmp2_plus_ref_o}, 32'h0000_0007);
        chk(32'(comparator_mode_field_o), 32'h0000_0006);
        rd(12'h200, 32'h0000_0000);
        chk(32'(last_err), 32'h0000_0001);
        close_out;
    end
endmodule // comparator_reference_control_tb_top
`default_nettype wire
